/* gpev_pkg.sv */
// package: constants and carriers for the gpio event and shifter block
package gpev_pkg;

    localparam int          GPEV_PINS        = 16;
    localparam int          GPEV_BANK_W      = 8;
    localparam int          GPEV_SYNC_STAGES = 2;
    // pins whose edge select lives in the local register
    localparam int          GPEV_LOC_PINS    = 4;

    localparam logic [7:0]  GPEV_OFS_EDGE_LO_A = 8'h17;
    localparam logic [7:0]  GPEV_OFS_SRC_B     = 8'h18;
    localparam logic [7:0]  GPEV_OFS_SRC_A     = 8'h19;
    localparam logic [7:0]  GPEV_OFS_EVT_B     = 8'h1A;
    localparam logic [7:0]  GPEV_OFS_EVT_A     = 8'h1B;
    localparam logic [7:0]  GPEV_OFS_SHIFT_UP  = 8'h1C;

    localparam logic [7:0]  GPEV_RST_EDGE_LO_A = 8'h00;
    localparam logic [15:0] GPEV_RST_SRC       = 16'h0000;
    localparam logic [15:0] GPEV_RST_EVT       = 16'h0000;
    localparam logic [7:0]  GPEV_RST_SHIFT_UP  = 8'h00;
    localparam logic [7:0]  GPEV_RD_UNMAPPED   = 8'h00;

    typedef enum logic [1:0] {
        GPEV_EDGE_NONE    = 2'h0,
        GPEV_EDGE_RISING  = 2'h1,
        GPEV_EDGE_FALLING = 2'h2,
        GPEV_EDGE_BOTH    = 2'h3
    } gpev_edge_e;

    typedef enum logic [1:0] {
        GPEV_SHIFT_OFF  = 2'h0,
        GPEV_SHIFT_A2B  = 2'h1,
        GPEV_SHIFT_B2A  = 2'h2,
        GPEV_SHIFT_RSVD = 2'h3
    } gpev_shift_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gpev_req_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } gpev_rsp_s;

endpackage : gpev_pkg

/* gpev_edge.sv */
// edge detector: pin synchroniser and per-pin edge selection
`timescale 1ns/10ps
module gpev_edge #(
    parameter int N = 16
) (
    input  wire logic           i_mclk,
    input  wire logic           i_nrst,
    input  wire logic [N-1:0]   i_pins,
    input  wire logic [2*N-1:0] i_sel,
    output logic      [N-1:0]   o_hit
);
    import gpev_pkg::*;

    logic [N-1:0] sync1_q;
    logic [N-1:0] sync2_q;
    logic [N-1:0] prev_q;
    logic [2:0]   prime_q;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end else begin
            sync1_q <= i_pins;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // no edges until the pipe holds real pin levels
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            prime_q <= 3'h0;
        end else begin
            prime_q <= {prime_q[1:0], 1'b1};
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pin
            logic rise;
            logic fall;
            assign rise = sync2_q[g] & ~prev_q[g];
            assign fall = ~sync2_q[g] & prev_q[g];
            always_comb begin
                unique case (gpev_edge_e'(i_sel[2*g +: 2]))
                    GPEV_EDGE_NONE:    o_hit[g] = 1'b0;
                    GPEV_EDGE_RISING:  o_hit[g] = prime_q[2] & rise;
                    GPEV_EDGE_FALLING: o_hit[g] = prime_q[2] & fall;
                    GPEV_EDGE_BOTH:    o_hit[g] = prime_q[2] & (rise | fall);
                endcase
            end
        end
    endgenerate

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    property p_sel_none_quiet;
        i_sel[1:0] == 2'h0 |-> !o_hit[0];
    endproperty
    a_sel_none_quiet: assert property (p_sel_none_quiet)
        else $error("pin 0 hit with edge select none");

    property p_rise_seen;
        (prime_q[2] && i_sel[1:0] == 2'h1 && sync2_q[0] && !prev_q[0])
            |-> o_hit[0];
    endproperty
    a_rise_seen: assert property (p_rise_seen)
        else $error("rising edge on pin 0 not detected");

endmodule : gpev_edge

/* gpev_top.sv */
// gpio event flags, interrupt output and upper level-shifter pairs
`timescale 1ns/10ps
// Notes on behaviour
// - pins 3, 2, 1, 0 have two-bit edge selects at bits 7:6, 5:4, 3:2, 1:0.
// - edge select 00 none, 01 rising, 10 falling, 11 both edges.
// - a mask bit of 0 lets the pin interrupt, 1 blocks it.
// - a selected edge on an unmasked pin sets its interrupt source bit.
// - writing 1 to a source bit clears it and its event bit, 0 keeps it.
// - the interrupt output returns high only when all source bits clear.
// - a selected edge sets the event bit regardless of the mask.
// - writing 1 to an event bit clears it and its source bit.
// - changing a pin's edge select clears its event and source bits.
// - shifter pairs 7/15, 6/14, 5/13, 4/12 sit at 7:6, 5:4, 3:2, 1:0.
// - shifter field 00 off, 01 a to b, 10 b to a, 11 reserved.
// - source, event and shifter registers reset to zero.
module gpev_top #(
    parameter int N_PINS = 16
) (
    input  wire logic                  i_mclk,
    input  wire logic                  i_nrst,
    input  wire gpev_pkg::gpev_req_s   i_reg_req,
    output gpev_pkg::gpev_rsp_s        o_reg_rsp,
    input  wire logic [N_PINS-1:0]     i_pin_value_bits,
    input  wire logic [N_PINS-1:0]     i_irq_mask_bits,
    input  wire logic [2*N_PINS-9:0]   i_edge_select_hi,
    output logic                       o_irq_out_n,
    output logic [7:0]                 o_shifter_pairs_upper,
    output logic [3:0]                 o_shift_a2b,
    output logic [3:0]                 o_shift_b2a
);
    import gpev_pkg::*;

    // refuse widths at elaboration: bank split below is fixed
    if (N_PINS != GPEV_PINS) begin : g_bad_pins
        $error("gpev_top serves exactly two banks of eight pins");
    end

    logic [7:0]          edge_lo_q;
    logic [2*N_PINS-1:0] sel_all;
    logic [2*N_PINS-1:0] sel_prev_q;
    logic [N_PINS-1:0]   sel_chg;
    logic [N_PINS-1:0]   hit;
    logic [N_PINS-1:0]   src_q;
    logic [N_PINS-1:0]   src_d;
    logic [N_PINS-1:0]   evt_q;
    logic [N_PINS-1:0]   evt_d;
    logic [N_PINS-1:0]   w1c;
    logic [N_PINS-1:0]   clr;
    logic [7:0]          shift_q;
    logic                irq_n_q;
    gpev_rsp_s           rsp_q;
    logic [7:0]          rd_mux;
    logic                wr_edge;
    logic                wr_shift;

    assign wr_edge  = i_reg_req.wr && i_reg_req.addr == GPEV_OFS_EDGE_LO_A;
    assign wr_shift = i_reg_req.wr && i_reg_req.addr == GPEV_OFS_SHIFT_UP;

    // local edge select word followed by the remaining pins
    assign sel_all = {i_edge_select_hi, edge_lo_q};

    gpev_edge #(
        .N (N_PINS)
    ) u_edge (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_pins (i_pin_value_bits),
        .i_sel  (sel_all),
        .o_hit  (hit)
    );

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            edge_lo_q <= GPEV_RST_EDGE_LO_A;
        end else if (wr_edge) begin
            edge_lo_q <= i_reg_req.wdata;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            sel_prev_q <= '0;
        end else begin
            sel_prev_q <= sel_all;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N_PINS; g++) begin : g_chg
            // any change of a field counts, writes of equal value do not
            assign sel_chg[g] = sel_all[2*g +: 2] != sel_prev_q[2*g +: 2];
        end
    endgenerate

    // a one written to either flag word clears both flags
    always_comb begin
        w1c = '0;
        if (i_reg_req.wr) begin
            unique case (i_reg_req.addr)
                GPEV_OFS_SRC_B, GPEV_OFS_EVT_B: w1c = {i_reg_req.wdata, 8'h00};
                GPEV_OFS_SRC_A, GPEV_OFS_EVT_A: w1c = {8'h00, i_reg_req.wdata};
                default:                        w1c = '0;
            endcase
        end
    end

    // select change clears alongside host clears
    assign clr = w1c | sel_chg;

    // set wins over a clear in the same cycle so no edge is lost
    always_comb begin
        evt_d = (evt_q & ~clr) | hit;
        // source set only for unmasked pins
        src_d = (src_q & ~clr) | (hit & ~i_irq_mask_bits);
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            evt_q <= GPEV_RST_EVT;
            src_q <= GPEV_RST_SRC;
        end else begin
            evt_q <= evt_d;
            src_q <= src_d;
        end
    end

    // output follows the next source state, no extra lag
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_n_q <= 1'b1;
        end else begin
            irq_n_q <= ~(|src_d);
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            shift_q <= GPEV_RST_SHIFT_UP;
        end else if (i_reg_req.wr && i_reg_req.addr == GPEV_OFS_SHIFT_UP) begin
            shift_q <= i_reg_req.wdata;
        end
    end

    generate
        for (g = 0; g < 4; g++) begin : g_shift
            logic [1:0] fld_d;
            assign fld_d = wr_shift ? i_reg_req.wdata[2*g +: 2]
                                    : shift_q[2*g +: 2];
            always_ff @(posedge i_mclk or negedge i_nrst) begin
                if (!i_nrst) begin
                    o_shift_a2b[g] <= 1'b0;
                    o_shift_b2a[g] <= 1'b0;
                end else begin
                    o_shift_a2b[g] <= fld_d == GPEV_SHIFT_A2B;
                    o_shift_b2a[g] <= fld_d == GPEV_SHIFT_B2A;
                end
            end
        end
    endgenerate

    always_comb begin
        unique case (i_reg_req.addr)
            GPEV_OFS_EDGE_LO_A: rd_mux = edge_lo_q;
            GPEV_OFS_SRC_B:     rd_mux = src_q[15:8];
            GPEV_OFS_SRC_A:     rd_mux = src_q[7:0];
            GPEV_OFS_EVT_B:     rd_mux = evt_q[15:8];
            GPEV_OFS_EVT_A:     rd_mux = evt_q[7:0];
            GPEV_OFS_SHIFT_UP:  rd_mux = shift_q;
            default:            rd_mux = GPEV_RD_UNMAPPED;
        endcase
    end

    // reads show flags as they stood before this cycle's update
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rsp_q <= '0;
        end else begin
            rsp_q.valid <= i_reg_req.rd;
            rsp_q.data  <= i_reg_req.rd ? rd_mux : 8'h00;
        end
    end

    assign o_reg_rsp             = rsp_q;
    assign o_irq_out_n           = irq_n_q;
    assign o_shifter_pairs_upper = shift_q;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    sequence s_write(logic [7:0] a);
        i_reg_req.wr && i_reg_req.addr == a;
    endsequence

    sequence s_quiet;
        hit == '0 && sel_chg == '0;
    endsequence

    property p_edge_write;
        s_write(GPEV_OFS_EDGE_LO_A) |=> edge_lo_q == $past(i_reg_req.wdata);
    endproperty
    a_edge_write: assert property (p_edge_write)
        else $error("edge select write not stored");

    property p_mask_blocks;
        (i_irq_mask_bits[0] && !src_q[0] && w1c == '0)
            |=> !src_q[0];
    endproperty
    a_mask_blocks: assert property (p_mask_blocks)
        else $error("masked pin 0 raised a source flag");

    property p_src_set;
        |(hit & ~i_irq_mask_bits) |=>
            (src_q & $past(hit & ~i_irq_mask_bits))
                == $past(hit & ~i_irq_mask_bits);
    endproperty
    a_src_set: assert property (p_src_set)
        else $error("unmasked edge did not set source flag");

    property p_src_w1c;
        (s_write(GPEV_OFS_SRC_A) and s_quiet) |=>
            ((src_q[7:0] | evt_q[7:0]) & $past(i_reg_req.wdata)) == 8'h00;
    endproperty
    a_src_w1c: assert property (p_src_w1c)
        else $error("source write of one left a flag set");

    property p_irq_high;
        src_q == '0 |-> o_irq_out_n;
    endproperty
    a_irq_high: assert property (p_irq_high)
        else $error("interrupt low with no source flag");

    property p_evt_set;
        |hit |=> (evt_q & $past(hit)) == $past(hit);
    endproperty
    a_evt_set: assert property (p_evt_set)
        else $error("selected edge did not set event flag");

    property p_evt_w1c;
        (s_write(GPEV_OFS_EVT_B) and s_quiet) |=>
            ((src_q[15:8] | evt_q[15:8]) & $past(i_reg_req.wdata)) == 8'h00;
    endproperty
    a_evt_w1c: assert property (p_evt_w1c)
        else $error("event write of one left a flag set");

    property p_sel_chg_clr;
        (sel_chg[0] && !hit[0]) |=> !evt_q[0] && !src_q[0];
    endproperty
    a_sel_chg_clr: assert property (p_sel_chg_clr)
        else $error("edge select change left pin 0 flags set");

    property p_shift_write;
        s_write(GPEV_OFS_SHIFT_UP) |=>
            o_shifter_pairs_upper == $past(i_reg_req.wdata)
            && o_shift_a2b[3] == ($past(i_reg_req.wdata[7:6]) == 2'h1)
            && o_shift_b2a[0] == ($past(i_reg_req.wdata[1:0]) == 2'h2);
    endproperty
    a_shift_write: assert property (p_shift_write)
        else $error("shifter write or decode wrong");

    property p_shift_rsvd;
        o_shifter_pairs_upper[3:2] == 2'h3
            |-> !o_shift_a2b[1] && !o_shift_b2a[1];
    endproperty
    a_shift_rsvd: assert property (p_shift_rsvd)
        else $error("reserved shifter code drives a direction");

    property p_irq_low;
        |src_q |-> !o_irq_out_n;
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("interrupt high while a source flag is set");

    property p_read_lat;
        i_reg_req.rd |=> o_reg_rsp.valid;
    endproperty
    a_read_lat: assert property (p_read_lat)
        else $error("read answer missing");

endmodule : gpev_top

/* gpev_host.sv */
// host model: register writes and reads issued toward the block
`timescale 1ns/10ps
module gpev_host (
    input  wire logic                i_mclk,
    input  wire gpev_pkg::gpev_rsp_s i_rsp,
    output gpev_pkg::gpev_req_s      o_req
);
    import gpev_pkg::*;

    // idle edges before each request, raised to act as a slow host
    int gap = 0;

    initial o_req = '0;

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        repeat (gap + 1) @(posedge i_mclk);
        #1 o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_mclk);
        #1 o_req = '0;
    endtask : wr

    // answer stands only in the cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        repeat (gap + 1) @(posedge i_mclk);
        #1 o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_mclk);
        #1 o_req = '0;
        d = i_rsp.valid ? i_rsp.data : 8'hXX;
    endtask : rd

endmodule : gpev_host

/* gpev_top_bench.sv */
// self-checking bench for the event flags, interrupt and shifter block
`timescale 1ns/10ps
module gpev_top_bench;
    import gpev_pkg::*;

    logic        mclk;
    logic        nrst;
    gpev_req_s   req;
    gpev_rsp_s   rsp;
    logic [15:0] pins;
    logic [15:0] mask;
    logic [23:0] sel_hi;
    logic        irq_n;
    logic [7:0]  shift_q;
    logic [3:0]  a2b;
    logic [3:0]  b2a;
    int          err_total;
    int          cmp_count;
    int          cycles;
    logic [7:0]  sh_val [2] = '{8'h42, 8'h6C};
    logic [3:0]  sh_a2b [2] = '{4'h8, 4'h8};
    logic [3:0]  sh_b2a [2] = '{4'h1, 4'h4};

    gpev_top u_gpev_top (
        .i_mclk                (mclk),
        .i_nrst                (nrst),
        .i_reg_req             (req),
        .o_reg_rsp             (rsp),
        .i_pin_value_bits      (pins),
        .i_irq_mask_bits       (mask),
        .i_edge_select_hi      (sel_hi),
        .o_irq_out_n           (irq_n),
        .o_shifter_pairs_upper (shift_q),
        .o_shift_a2b           (a2b),
        .o_shift_b2a           (b2a)
    );

    gpev_host u_gpev_host (
        .i_mclk (mclk),
        .i_rsp  (rsp),
        .o_req  (req)
    );

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_gpev_host.rd(a, d);
        chk(d, exp);
    endtask : rchk

    // let the two-stage sync and compare stage settle
    task automatic setpins(input logic [15:0] v);
        @(posedge mclk);
        #1 pins = v;
        repeat (5) @(posedge mclk);
    endtask : setpins

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // a hung handshake ends the run as a failure
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        nrst = 1'b0;
        pins = 16'h0000;
        mask = 16'hFFFF;
        sel_hi = 24'h000000;
        err_total = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (4) @(posedge mclk);
        #1 nrst = 1'b1;
        repeat (4) @(posedge mclk);
        chk({7'h00, irq_n}, 8'h01);
        for (int a = 8'h18; a <= 8'h1C; a++) begin
            rchk(a[7:0], 8'h00);
        end
        u_gpev_host.wr(8'h30, 8'hFF);
        rchk(8'h30, 8'h00);
        u_gpev_host.gap = 2;
        for (int i = 0; i < 2; i++) begin
            u_gpev_host.wr(8'h1C, sh_val[i]);
            @(posedge mclk);
            #1 chk(shift_q, sh_val[i]);
            chk({4'h0, a2b}, {4'h0, sh_a2b[i]});
            chk({4'h0, b2a}, {4'h0, sh_b2a[i]});
            rchk(8'h1C, sh_val[i]);
        end
        u_gpev_host.gap = 0;
        // every select code on pin 0 with all pins masked
        for (int c = 0; c < 4; c++) begin
            u_gpev_host.wr(8'h17, c[7:0]);
            setpins(16'h0001);
            rchk(8'h1B, {7'h00, c[0]});
            u_gpev_host.wr(8'h1B, 8'h01);
            setpins(16'h0000);
            rchk(8'h1B, {7'h00, c[1]});
            u_gpev_host.wr(8'h1B, 8'h01);
        end
        rchk(8'h19, 8'h00);
        u_gpev_host.wr(8'h17, 8'h10);
        setpins(16'h0004);
        rchk(8'h1B, 8'h04);
        u_gpev_host.wr(8'h1B, 8'h04);
        setpins(16'h0000);
        // pins 0 and 12 unmasked, pin 1 masked
        #1 mask = 16'hEFFE;
        sel_hi = 24'h010000;
        u_gpev_host.wr(8'h17, 8'h05);
        setpins(16'h1003);
        rchk(8'h1B, 8'h03);
        rchk(8'h19, 8'h01);
        rchk(8'h18, 8'h10);
        rchk(8'h1A, 8'h10);
        chk({7'h00, irq_n}, 8'h00);
        u_gpev_host.wr(8'h19, 8'h01);
        rchk(8'h1B, 8'h02);
        rchk(8'h19, 8'h00);
        chk({7'h00, irq_n}, 8'h00);
        u_gpev_host.wr(8'h18, 8'h00);
        rchk(8'h18, 8'h10);
        u_gpev_host.wr(8'h1A, 8'h10);
        rchk(8'h18, 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        u_gpev_host.wr(8'h17, 8'h09);
        rchk(8'h1B, 8'h00);
        rchk(8'h17, 8'h09);
        close_out();
    end

endmodule : gpev_top_bench
